/* fsam_pkg.sv */
package fsam_pkg;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 50;
   localparam int BUSY_TIME_NS = 5000;
   localparam int BUSY_CYCLES = (BUSY_TIME_NS + CLK_PERIOD_NS - 1) /
      CLK_PERIOD_NS;
   localparam logic [7:0] BUSY_LOAD = 8'(BUSY_CYCLES);

   // ------------------------------------------------------------
   // Status register layout
   // ------------------------------------------------------------
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam int WIP_BIT = 0;
   localparam int WEL_BIT = 1;
   localparam int NV_LSB = 2;
   localparam int QE_BIT = 6;
   localparam int LOCK_BIT = 7;

   // ------------------------------------------------------------
   // Instruction codes
   // ------------------------------------------------------------
   localparam logic [7:0] CMD_READ_STATUS = 8'h05;
   localparam logic [7:0] CMD_SET_WEL = 8'h06;
   localparam logic [7:0] CMD_CLR_WEL = 8'h04;
   localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
   localparam logic [7:0] CMD_SOFT_RESET = 8'h99;
   localparam logic [7:0] CMD_SUSPEND = 8'h75;
   localparam logic [7:0] CMD_RESUME = 8'h7A;
   localparam logic [7:0] CMD_ERASE_4K = 8'h21;
   localparam logic [7:0] CMD_ERASE_32K = 8'h5C;
   localparam logic [7:0] CMD_ERASE_64K = 8'hDC;

   // ------------------------------------------------------------
   // Array geometry
   // ------------------------------------------------------------
   localparam int SECTOR_LSB = 12;
   localparam int ADDR_MSB = 24;
   localparam int BLK64_LSB = 4;
   localparam logic [4:0] SPAN_4K = 5'h01;
   localparam logic [4:0] SPAN_32K = 5'h08;
   localparam logic [4:0] SPAN_64K = 5'h10;
   localparam logic [9:0] BLK64_TOTAL = 10'h200;
   localparam logic [3:0] SYNC_RESET = 4'h9;

   typedef enum logic [1:0] {
      PH_CMD = 2'b00,
      PH_ADDR = 2'b01,
      PH_DATA = 2'b11,
      PH_SKIP = 2'b10
   } fsam_phase_t;

endpackage

/* fsam_sync.sv */
`timescale 1ns/1ps
module fsam_sync
   import fsam_pkg::*;
#(
   parameter int W = 4,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } fsam_sync_t;

   fsam_sync_t q;
   fsam_sync_t next_q;

   always_comb begin
      next_q.s1 = d_i;
      next_q.s2 = q.s1;
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         q <= {RST_VAL, RST_VAL};
      end else begin
         q <= next_q;
      end
   end

   assign q_o = q.s2;

endmodule // fsam_sync

/* fsam_status.sv */
`timescale 1ns/1ps
module fsam_status
   import fsam_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic cs_n_i,
   input wire logic sck_i,
   input wire logic mosi_i,
   input wire logic wp_n_i,
   output logic miso_o,
   output logic miso_oe_o,
   output logic [7:0] status_o,
   output logic quad_enable_o,
   output logic [3:0] protect_o,
   output logic erase_go_o,
   output logic [12:0] erase_sector_o,
   output logic [4:0] erase_count_o
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic sck_d;
      logic cs_d;
      logic [2:0] bit_cnt;
      logic [6:0] sh;
      logic [7:0] cmd;
      logic cmd_ok;
      fsam_phase_t phase;
      logic [31:0] addr;
      logic [1:0] byte_cnt;
      logic addr_ok;
      logic [7:0] wdata;
      logic wdata_ok;
      logic [6:0] out;
      logic miso;
      logic [5:0] nv;
      logic write_enable_latch;
      logic [7:0] busy_cnt;
      logic susp;
      logic go;
      logic [12:0] sect;
      logic [4:0] cnt;
   } fsam_state_t;

   fsam_state_t q;
   fsam_state_t next_q;
   logic [3:0] pins_s;
   logic cs_n_s, sck_s, mosi_s, wp_n_s;
   logic write_in_progress, sck_rise, sck_fall, cs_rise, allowed, prot_hit;
   logic [7:0] status, byte_in;
   logic [4:0] span;
   logic [12:0] first, last;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   fsam_sync #(.W(4), .RST_VAL(SYNC_RESET)) u_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .d_i({cs_n_i, sck_i, mosi_i, wp_n_i}),
      .q_o(pins_s)
   );
   assign {cs_n_s, sck_s, mosi_s, wp_n_s} = pins_s;

   function automatic logic prot_f(input logic [8:0] blk,
                                   input logic [3:0] bp);
      logic [9:0] thr;
      thr = BLK64_TOTAL - (10'h001 << (bp - 4'h1));
      if (bp == 4'h0) begin
         return 1'b0;
      end
      if (bp >= 4'hA) begin
         return 1'b1;
      end
      return {1'b0, blk} >= thr;
   endfunction

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   assign write_in_progress = (q.busy_cnt != 8'h00) && !q.susp;
   assign status = {q.nv, q.write_enable_latch, write_in_progress};
   assign sck_rise = sck_s && !q.sck_d;
   assign sck_fall = !sck_s && q.sck_d;
   assign cs_rise = cs_n_s && !q.cs_d;
   assign byte_in = {q.sh, mosi_s};
   assign allowed = (byte_in == CMD_READ_STATUS) ||
      (byte_in == CMD_SOFT_RESET) || (byte_in == CMD_SUSPEND) ||
      (byte_in == CMD_RESUME);

   always_comb begin
      case (q.cmd)
         CMD_ERASE_32K: span = SPAN_32K;
         CMD_ERASE_64K: span = SPAN_64K;
         default: span = SPAN_4K;
      endcase
   end

   // Sector index and block alignment
   assign first = q.addr[ADDR_MSB:SECTOR_LSB] &
      ~{8'h00, span - 5'h01};
   assign last = first | {8'h00, span - 5'h01};
   assign prot_hit = prot_f(last[12:BLK64_LSB],
      q.nv[3:0]);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_q = q;
      next_q.go = 1'b0;
      next_q.sck_d = sck_s;
      next_q.cs_d = cs_n_s;
      if (q.busy_cnt != 8'h00 && !q.susp) begin
         next_q.busy_cnt = q.busy_cnt - 8'h01;
         if (q.busy_cnt == 8'h01) begin
            next_q.write_enable_latch = 1'b0;
         end
      end
      if (cs_n_s) begin
         next_q.phase = PH_CMD;
         next_q.bit_cnt = 3'h0;
         next_q.byte_cnt = 2'h0;
         next_q.cmd_ok = 1'b0;
         next_q.addr_ok = 1'b0;
         next_q.wdata_ok = 1'b0;
      end else if (sck_rise) begin
         next_q.sh = byte_in[6:0];
         next_q.bit_cnt = q.bit_cnt + 3'h1;
         if (q.bit_cnt == 3'h7) begin
            unique case (q.phase)
               PH_CMD: begin
                  next_q.cmd = byte_in;
                  next_q.cmd_ok = !(write_in_progress && !allowed);
                  if (write_in_progress && !allowed) begin
                     next_q.phase = PH_SKIP;
                  end else if (byte_in == CMD_READ_STATUS ||
                               byte_in == CMD_WRITE_STATUS) begin
                     next_q.phase = PH_DATA;
                  end else if (byte_in == CMD_ERASE_4K ||
                               byte_in == CMD_ERASE_32K ||
                               byte_in == CMD_ERASE_64K) begin
                     next_q.phase = PH_ADDR;
                  end else begin
                     next_q.phase = PH_SKIP;
                  end
               end
               PH_ADDR: begin
                  next_q.addr = {q.addr[23:0], byte_in};
                  next_q.byte_cnt = q.byte_cnt + 2'h1;
                  if (q.byte_cnt == 2'h3) begin
                     next_q.addr_ok = 1'b1;
                     next_q.phase = PH_SKIP;
                  end
               end
               PH_DATA: begin
                  if (q.cmd == CMD_WRITE_STATUS) begin
                     next_q.wdata = byte_in;
                     next_q.wdata_ok = 1'b1;
                     next_q.phase = PH_SKIP;
                  end
               end
               PH_SKIP: begin
               end
            endcase
         end
      end else if (sck_fall && q.phase == PH_DATA) begin
         // Fresh value at every byte boundary
         if (q.bit_cnt == 3'h0) begin
            next_q.miso = status[7];
            next_q.out = status[6:0];
         end else begin
            next_q.miso = q.out[6];
            next_q.out = {q.out[5:0], 1'b0};
         end
      end
      // Execute on chip select release
      if (cs_rise && q.cmd_ok) begin
         case (q.cmd)
            CMD_SET_WEL: if (q.busy_cnt == 8'h00) begin
               next_q.write_enable_latch = 1'b1;
            end
            CMD_CLR_WEL: next_q.write_enable_latch = 1'b0;
            CMD_SOFT_RESET: begin
               next_q.busy_cnt = 8'h00;
               next_q.write_enable_latch = 1'b0;
               next_q.susp = 1'b0;
            end
            CMD_SUSPEND: next_q.susp = next_q.busy_cnt != 8'h00;
            CMD_RESUME: next_q.susp = 1'b0;
            CMD_WRITE_STATUS: begin
               if (q.busy_cnt == 8'h00 && q.write_enable_latch && q.wdata_ok &&
                   !(q.nv[LOCK_BIT-NV_LSB] && !wp_n_s)) begin
                  next_q.nv = q.wdata[7:NV_LSB];
                  next_q.busy_cnt = BUSY_LOAD;
               end
            end
            CMD_ERASE_4K, CMD_ERASE_32K, CMD_ERASE_64K: begin
               if (q.busy_cnt == 8'h00 && q.write_enable_latch && q.addr_ok &&
                   !prot_hit) begin
                  next_q.go = 1'b1;
                  next_q.sect = first;
                  next_q.cnt = span;
                  next_q.busy_cnt = BUSY_LOAD;
               end
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         q <= '0;
         q.nv <= STATUS_RESET[7:NV_LSB];
         q.write_enable_latch <= STATUS_RESET[WEL_BIT];
         q.cs_d <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign miso_o = q.miso;
   assign miso_oe_o = !cs_n_s && q.phase == PH_DATA &&
      q.cmd == CMD_READ_STATUS;
   assign status_o = status;
   assign quad_enable_o = q.nv[QE_BIT-NV_LSB];
   assign protect_o = q.nv[3:0];
   assign erase_go_o = q.go;
   assign erase_sector_o = q.sect;
   assign erase_count_o = q.cnt;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   a_wel_set_cmd: assert property (cs_rise && q.cmd_ok &&
      q.cmd == CMD_SET_WEL && q.busy_cnt == 8'h00 |=> q.write_enable_latch)
      else $error("latch not set by set command");
   a_wel_clear_cmd: assert property (cs_rise && q.cmd_ok &&
      q.cmd == CMD_CLR_WEL |=> !q.write_enable_latch)
      else $error("latch not cleared by clear command");
   a_wel_on_done: assert property (q.busy_cnt == 8'h01 &&
      !q.susp |=> !q.write_enable_latch && !status_o[WIP_BIT])
      else $error("latch or busy left after completion");
   a_busy_ignore: assert property (!cs_n_s && sck_rise &&
      q.bit_cnt == 3'h7 && q.phase == PH_CMD && write_in_progress && !allowed
      |=> q.phase == PH_SKIP && !q.cmd_ok)
      else $error("command taken while busy");
   a_lock_holds: assert property (q.nv[LOCK_BIT-NV_LSB] &&
      !wp_n_s && cs_rise |=> $stable(q.nv))
      else $error("locked status changed");
   a_read_repeat: assert property (sck_fall && !cs_n_s &&
      q.phase == PH_DATA && q.cmd == CMD_READ_STATUS &&
      q.bit_cnt == 3'h0 |=> q.miso == $past(status[7]))
      else $error("status byte not restarted");
   a_block_align: assert property (erase_go_o |->
      (erase_sector_o & {8'h00, erase_count_o - 5'h01}) == 13'h0000)
      else $error("erase span misaligned");
   a_no_prot_erase: assert property (cs_rise && prot_hit &&
      q.addr_ok |=> !erase_go_o)
      else $error("erase inside protected area");
   a_busy_length: assert property (erase_go_o |->
      status_o[WIP_BIT] [*8])
      else $error("busy flag dropped early");
   a_oe_release: assert property (cs_n_s |=> q.phase == PH_CMD &&
      !miso_oe_o) else $error("output driven while deselected");

   c_read_status: cover property (miso_oe_o [*8]);
   c_erase_go: cover property (erase_go_o);
   c_status_write: cover property (cs_rise && q.cmd_ok &&
      q.cmd == CMD_WRITE_STATUS && q.wdata_ok);
   c_busy_reject: cover property (q.phase == PH_SKIP && write_in_progress);

endmodule // fsam_status

/* fsam_host_model.sv */
`timescale 1ns/1ps
module fsam_host_model
   import fsam_pkg::*;
(
   input wire logic clk_i,
   input wire logic miso_i,
   output logic cs_n_o,
   output logic sck_o,
   output logic mosi_o
);
   // ---------------------------------
   // Serial host, mode 0, slow clock
   // ---------------------------------
   initial begin
      cs_n_o = 1'b1;
      sck_o = 1'b0;
      mosi_o = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         mosi_o = tx[i];
         tick(4);
         sck_o = 1'b1;
         tick(4);
         rx[i] = miso_i;
         sck_o = 1'b0;
      end
   endtask

   task automatic open();
      cs_n_o = 1'b0;
      tick(4);
   endtask

   task automatic put(input logic [7:0] tx);
      logic [7:0] rx;
      xfer(tx, rx);
   endtask

   // Released data line flips
   task automatic close();
      tick(4);
      cs_n_o = 1'b1;
      mosi_o = ~mosi_o;
      tick(6);
   endtask

   // Poll busy before next command
   task automatic wait_ready();
      logic [7:0] rx;
      for (int k = 0; k < 10; k++) begin
         open();
         put(CMD_READ_STATUS);
         xfer(8'h00, rx);
         close();
         if (rx[WIP_BIT] === 1'b0) break;
      end
   endtask
endmodule // fsam_host_model

/* test_flash_status_and_array_map.sv */
`timescale 1ns/1ps
module test_flash_status_and_array_map
   import fsam_pkg::*;
;
   logic clk_i, rst_n_i, cs_n_i, sck_i, mosi_i, wp_n_i, miso_w, miso_q;
   logic miso_o, miso_oe_o, quad_enable_o, erase_go_o;
   logic [7:0] status_o;
   logic [3:0] protect_o;
   logic [12:0] erase_sector_o;
   logic [4:0] erase_count_o;
   int n_errors = 0;
   int comparisons = 0;
   int n_go = 0;
   logic [7:0] e_op [4] = '{CMD_ERASE_4K, CMD_ERASE_32K, CMD_ERASE_64K,
      CMD_ERASE_64K};
   logic [31:0] e_adr [4] = '{32'h01234567, 32'h01234567, 32'h01234567,
      32'h01FF8000};
   logic [12:0] e_cnt [4] = '{13'h0001, 13'h0008, 13'h0010, 13'h0010};
   logic [12:0] e_sec [4] = '{13'h1234, 13'h1230, 13'h1230, 13'h1FF0};

   // ---------------------------------
   // Clock, wire, instances
   // ---------------------------------
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   assign miso_w = miso_oe_o ? miso_o : ~miso_q;
   always @(posedge clk_i) begin
      miso_q <= miso_w;
      if (erase_go_o === 1'b1) n_go++;
   end

   fsam_status i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i),
      .sck_i(sck_i), .mosi_i(mosi_i), .wp_n_i(wp_n_i), .miso_o(miso_o),
      .miso_oe_o(miso_oe_o), .status_o(status_o),
      .quad_enable_o(quad_enable_o), .protect_o(protect_o),
      .erase_go_o(erase_go_o), .erase_sector_o(erase_sector_o),
      .erase_count_o(erase_count_o));

   fsam_host_model i_host (.clk_i(clk_i), .miso_i(miso_w),
      .cs_n_o(cs_n_i), .sck_o(sck_i), .mosi_o(mosi_i));

   // ---------------------------------
   // Tasks
   // ---------------------------------
   task automatic chk(input string nm, input logic [12:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic cmd(input logic [7:0] op);
      i_host.open();
      i_host.put(op);
      i_host.close();
   endtask

   task automatic status_write_cmd(input logic [7:0] v);
      i_host.open();
      i_host.put(CMD_WRITE_STATUS);
      i_host.put(v);
      i_host.close();
   endtask

   task automatic erase(input logic [7:0] op, input logic [31:0] a);
      i_host.open();
      i_host.put(op);
      for (int k = 3; k >= 0; k--) i_host.put(a[k*8 +: 8]);
      i_host.close();
   endtask

   // Three bytes in one frame
   task automatic rdsr(input logic [7:0] exp);
      logic [7:0] rx;
      i_host.open();
      i_host.put(CMD_READ_STATUS);
      for (int k = 0; k < 3; k++) begin
         i_host.xfer(8'h00, rx);
         chk("read status", rx, exp);
         chk("miso enable", miso_oe_o, 1'b1);
      end
      i_host.close();
      chk("miso enable idle", miso_oe_o, 1'b0);
   endtask

   task automatic tally_and_finish();
      if (n_errors == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ---------------------------------
   // Tests
   // ---------------------------------
   initial begin
      repeat (20000) @(posedge clk_i);
      n_errors++;
      tally_and_finish();
   end

   initial begin
      rst_n_i = 1'b0;
      wp_n_i = 1'b1;
      repeat (10) @(negedge clk_i);
      rst_n_i = 1'b1;
      i_host.tick(4);
      chk("status reset", status_o, 8'h00);
      rdsr(8'h00);
      cmd(CMD_SET_WEL);
      chk("latch set", status_o, 8'h02);
      cmd(CMD_CLR_WEL);
      chk("latch clear", status_o, 8'h00);
      status_write_cmd(8'hC4);
      chk("write no latch", status_o, 8'h00);
      cmd(CMD_SET_WEL);
      status_write_cmd(8'hC4);
      chk("busy", status_o, 8'hC7);
      cmd(CMD_CLR_WEL);
      chk("busy ignores", status_o, 8'hC7);
      i_host.wait_ready();
      chk("done", status_o, 8'hC4);
      chk("quad", quad_enable_o, 1'b1);
      chk("protect", protect_o, 4'h1);
      rdsr(8'hC4);
      wp_n_i = 1'b0;
      cmd(CMD_SET_WEL);
      status_write_cmd(8'h00);
      chk("locked write", status_o, 8'hC6);
      erase(CMD_ERASE_64K, 32'h01FF8000);
      chk("protected erase", n_go, 0);
      wp_n_i = 1'b1;
      status_write_cmd(8'h00);
      i_host.wait_ready();
      chk("unlocked write", status_o, 8'h00);
      for (int k = 0; k < 4; k++) begin
         cmd(CMD_SET_WEL);
         erase(e_op[k], e_adr[k]);
         chk("erase pulses", n_go, k + 1);
         chk("erase sector", erase_sector_o, e_sec[k]);
         chk("erase count", erase_count_o, e_cnt[k]);
         i_host.wait_ready();
         chk("erase done", status_o, 8'h00);
      end
      cmd(CMD_SET_WEL);
      status_write_cmd(8'h00);
      cmd(CMD_SUSPEND);
      chk("suspended", status_o, 8'h02);
      cmd(CMD_RESUME);
      chk("resumed", status_o, 8'h03);
      i_host.wait_ready();
      chk("resume done", status_o, 8'h00);
      cmd(CMD_SET_WEL);
      status_write_cmd(8'h00);
      cmd(CMD_SUSPEND);
      chk("suspended again", status_o, 8'h02);
      cmd(CMD_SOFT_RESET);
      chk("soft reset", status_o, 8'h00);
      rdsr(8'h00);
      tally_and_finish();
   end
endmodule // test_flash_status_and_array_map
